// *** src/tpf_pkg.sv ***
// Purpose: shared constants for the table-pointer flash sequencer
// Assumes: byte-wide register port, 100 MHz clk_sys
// Notes: register offsets index the plain register port
package tpf_pkg;
  localparam int PTR_W = 22;
  localparam int LOW_W = 21;
  localparam int HOLD_W = 6;
  localparam int ROW_LSB = 10;
  localparam int BLK_LSB = 6;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_PTR_LOW = 4'h0;
  localparam logic [3:0] OFS_PTR_HIGH = 4'h1;
  localparam logic [3:0] OFS_PTR_UPPER = 4'h2;
  localparam logic [3:0] OFS_LATCH = 4'h3;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_KEY = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  localparam int CTRL_START = 1;
  localparam int CTRL_WEN = 2;
  localparam int CTRL_ERR = 3;
  localparam int CTRL_ERASE = 4;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int ERASE_TIME_US = 10;
  localparam int WRITE_TIME_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {TPF_NOCHG, TPF_POSTINC, TPF_POSTDEC, TPF_PREINC} tpf_mode_e;
  typedef enum {TPF_IDLE, TPF_LONG} tpf_state_e;
endpackage : tpf_pkg

// *** src/tpf_flash_if.sv ***
// Purpose: link between sequencer and its flash array model
// Assumes: single clock
// Notes: read data returns combinationally
`timescale 1ns/10ps
interface tpf_flash_if;
  logic [tpf_pkg::PTR_W-2:0] word_addr;
  logic [15:0] rd_word;
  logic erase_req;
  logic prog_req;
  logic [tpf_pkg::LOW_W-1:0] blk_addr;
  logic [7:0] hold_data [64];
  modport seq (output word_addr, erase_req, prog_req, blk_addr, hold_data, input rd_word);
  modport arr (input word_addr, erase_req, prog_req, blk_addr, hold_data, output rd_word);
endinterface : tpf_flash_if

// *** src/tpf_flash_array.sv ***
// Purpose: program flash array in 16-bit words
// Assumes: erase sets bytes to ff, programming ANDs in data
// Notes: word array is sized by parameter; upper space reads from same array
`timescale 1ns/10ps
module tpf_flash_array import tpf_pkg::*; #(
  parameter int WORDS = 4096
) (
  // Clock
  input wire logic clk_sys,
  // Sequencer link
  tpf_flash_if.arr fl
);
  localparam int AW = $clog2(WORDS);
  logic [15:0] mem [WORDS];
  logic [AW-1:0] ra;
  assign ra = fl.word_addr[AW-1:0];
  assign fl.rd_word = mem[ra];
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < WORDS; i++) begin
      if (fl.erase_req && (AW'(i) >> (ROW_LSB - 1)) == (fl.blk_addr[AW:1] >> (ROW_LSB - 1))) begin
        mem[i] <= 16'hffff;
      end else if (fl.prog_req && (AW'(i) >> (BLK_LSB - 1)) == (fl.blk_addr[AW:1] >> (BLK_LSB - 1))) begin
        mem[i] <= mem[i] & {fl.hold_data[2 * (i % 32) + 1], fl.hold_data[2 * (i % 32)]};
      end
    end
  end
endmodule : tpf_flash_array

// *** src/tpf_sequencer.sv ***
// Purpose: table pointer, table latch, holding registers and erase/program sequencer
// Assumes: core waits while stall is high; register port answers one cycle later
// Notes: long-cycle duration set by parameters
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module tpf_sequencer import tpf_pkg::*; #(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Table operations from the core
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [1:0] table_mode,
  output logic table_done,
  // Core stall
  output logic core_stall
);
  localparam int TW = $clog2((ERASE_CYCLES > WRITE_CYCLES ? ERASE_CYCLES : WRITE_CYCLES) + 1);

  tpf_flash_if fl ();
  tpf_flash_array u_array (
    .clk_sys(clk_sys),
    .fl(fl)
  );

  function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic dec);
    logic [LOW_W-1:0] low;
    low = dec ? p[LOW_W-1:0] - 1'b1 : p[LOW_W-1:0] + 1'b1;
    return {p[PTR_W-1], low};
  endfunction : step_ptr

  tpf_state_e state_reg, state_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic [7:0] latch_reg, latch_next;
  logic [7:0] hold_reg [64];
  logic [7:0] hold_next [64];
  logic wen_reg, wen_next, erase_reg, erase_next, start_reg, start_next, err_reg, err_next;
  logic [1:0] key_reg, key_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic op_erase_reg, op_erase_next;
  logic [7:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic err_seen_reg;
  logic bad_start;
  logic [PTR_W-1:0] acc_ptr;
  logic [7:0] rd_byte;

  // A reset during a long cycle is remembered via this flag being set at start
  always_comb begin
    acc_ptr = (tpf_mode_e'(table_mode) == TPF_PREINC) ? step_ptr(ptr_reg, 1'b0) : ptr_reg;
  end
  assign fl.word_addr = acc_ptr[PTR_W-1:1];
  assign rd_byte = acc_ptr[0] ? fl.rd_word[15:8] : fl.rd_word[7:0];
  assign fl.blk_addr = ptr_reg[LOW_W-1:0];
  assign fl.erase_req = (state_reg == TPF_LONG) && op_erase_reg && timer_reg == '0;
  assign fl.prog_req = (state_reg == TPF_LONG) && !op_erase_reg && timer_reg == '0;
  assign fl.hold_data = hold_reg;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    latch_next = latch_reg;
    hold_next = hold_reg;
    wen_next = wen_reg;
    erase_next = erase_reg;
    start_next = start_reg;
    err_next = err_reg;
    key_next = key_reg;
    timer_next = timer_reg;
    op_erase_next = op_erase_reg;
    rdata_next = 8'h00;
    done_next = 1'b0;
    bad_start = 1'b0;
    // Table ops are ignored during a long cycle since the core is halted
    if (state_reg == TPF_IDLE && (table_read_op || table_write_op)) begin
      if (table_read_op) begin
        latch_next = rd_byte;
      end else begin
        hold_next[acc_ptr[HOLD_W-1:0]] = latch_reg;
      end
      case (tpf_mode_e'(table_mode))
        TPF_NOCHG: ptr_next = ptr_reg;
        TPF_POSTINC: ptr_next = step_ptr(ptr_reg, 1'b0);
        TPF_POSTDEC: ptr_next = step_ptr(ptr_reg, 1'b1);
        TPF_PREINC: ptr_next = acc_ptr;
        default: ptr_next = ptr_reg;
      endcase
      done_next = 1'b1;
    end
    if (reg_wr) begin
      // Any register write other than the second key byte breaks the unlock
      key_next = 2'd0;
      case (reg_addr)
        OFS_PTR_LOW: ptr_next[7:0] = reg_wdata;
        OFS_PTR_HIGH: ptr_next[15:8] = reg_wdata;
        OFS_PTR_UPPER: ptr_next[PTR_W-1:16] = reg_wdata[PTR_W-17:0];
        OFS_LATCH: latch_next = reg_wdata;
        OFS_KEY: begin
          if (reg_wdata == KEY_FIRST) begin
            key_next = 2'd1;
          end else if (reg_wdata == KEY_SECOND && key_reg == 2'd1) begin
            key_next = 2'd2;
          end
        end
        OFS_CTRL: begin
          if (state_reg == TPF_IDLE) begin
            wen_next = reg_wdata[CTRL_WEN];
            erase_next = reg_wdata[CTRL_ERASE];
            err_next = reg_wdata[CTRL_ERR];
            if (reg_wdata[CTRL_START]) begin
              if (key_reg == 2'd2 && reg_wdata[CTRL_WEN] && wen_reg) begin
                start_next = 1'b1;
                err_next = 1'b1;
                op_erase_next = reg_wdata[CTRL_ERASE];
                timer_next = reg_wdata[CTRL_ERASE] ? TW'(ERASE_CYCLES) : TW'(WRITE_CYCLES);
                state_next = TPF_LONG;
              end else begin
                err_next = 1'b1;
                bad_start = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_PTR_LOW: rdata_next = ptr_reg[7:0];
        OFS_PTR_HIGH: rdata_next = ptr_reg[15:8];
        OFS_PTR_UPPER: rdata_next = {2'b00, ptr_reg[PTR_W-1:16]};
        OFS_LATCH: rdata_next = latch_reg;
        OFS_CTRL: rdata_next = {3'b000, erase_reg, err_reg, wen_reg, start_reg, 1'b0};
        OFS_KEY: rdata_next = 8'h00;
        OFS_STATUS: rdata_next = {6'h00, err_seen_reg, state_reg == TPF_LONG};
        default: rdata_next = 8'h00;
      endcase
    end
    if (state_reg == TPF_LONG) begin
      if (timer_reg == '0) begin
        state_next = TPF_IDLE;
        start_next = 1'b0;
        err_next = 1'b0;
        if (op_erase_reg) begin
          erase_next = 1'b0;
        end
      end else begin
        timer_next = timer_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= TPF_IDLE;
      ptr_reg <= '0;
      latch_reg <= 8'h00;
      wen_reg <= 1'b0;
      erase_reg <= 1'b0;
      start_reg <= 1'b0;
      key_reg <= 2'd0;
      timer_reg <= '0;
      op_erase_reg <= 1'b0;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
      core_stall <= 1'b0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      latch_reg <= latch_next;
      wen_reg <= wen_next;
      erase_reg <= erase_next;
      start_reg <= start_next;
      key_reg <= key_next;
      timer_reg <= timer_next;
      op_erase_reg <= op_erase_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      core_stall <= (state_next == TPF_LONG);
    end
  end

  // Error flag survives reset so a cut-short cycle stays visible
  always_ff @(posedge clk_sys) begin
    err_reg <= err_next;
    // Sticky record of refused starts; built from the refusal itself since the error flag is unknown after power-up
    err_seen_reg <= rst ? 1'b0 : (err_seen_reg | bad_start);
  end

  // Holding registers are not cleared by reset or by a programming cycle
  always_ff @(posedge clk_sys) begin
    hold_reg <= hold_next;
  end

  assign reg_rdata = rdata_reg;
  assign table_done = done_reg;
endmodule : tpf_sequencer

// *** dv/tpf_seq_assertions.sv ***
// Purpose: port checks for tpf_sequencer
// Assumes: one clock, sync reset
// Notes: attached by bind from the bench top
`timescale 1ns/10ps
module tpf_seq_chk import tpf_pkg::*; #(
  parameter int ERASE_CYCLES = 8,
  parameter int WRITE_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core side
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [1:0] table_mode,
  input wire logic table_done,
  input wire logic core_stall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic op;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  assign op = table_read_op | table_write_op;
  // Length of the current stall, read when it ends
  always_comb cnt_next = core_stall ? cnt_reg + 16'h1 : 16'h0;
  always_ff @(posedge clk_sys) cnt_reg <= rst ? 16'h0 : cnt_next;
  chk_op_done: assert property (op && !core_stall |=> table_done) else $error("op not acked");
  chk_done_cause: assert property (table_done |-> $past(op && !core_stall)) else $error("stray done");
  chk_stall_blocks: assert property (core_stall && op |=> !table_done) else $error("op ran in stall");
  chk_key_zero: assert property ($past(reg_rd && reg_addr == OFS_KEY) |-> reg_rdata == 8'h00)
    else $error("key port not zero");
  chk_stall_cause: assert property ($rose(core_stall) |->
    $past(reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START] && reg_wdata[CTRL_WEN])) else $error("bad stall");
  chk_wen_needed: assert property (reg_wr && reg_addr == OFS_CTRL && !reg_wdata[CTRL_WEN] && !core_stall
    |=> !core_stall) else $error("cycle without wen");
  // A stall ended by reset has no length to check
  chk_stall_len: assert property ($fell(core_stall) && !$past(rst) |->
    (cnt_reg >= ERASE_CYCLES && cnt_reg <= ERASE_CYCLES + 2)
    || (cnt_reg >= WRITE_CYCLES && cnt_reg <= WRITE_CYCLES + 2)) else $error("stall length");
  chk_start_busy: assert property ($past(reg_rd && reg_addr == OFS_CTRL && core_stall)
    |-> reg_rdata[CTRL_START] && reg_rdata[CTRL_ERR]) else $error("start bit low in cycle");
endmodule : tpf_seq_chk

// *** dv/tpf_core_model.sv ***
// Purpose: processor core issuing register accesses and table ops
// Assumes: each request starts right after a rising edge
// Notes: an idle cycle follows each request so strobes never merge
`timescale 1ns/10ps
module tpf_core_model import tpf_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Table ops
  output logic table_read_op,
  output logic table_write_op,
  output logic [1:0] table_mode,
  input wire logic table_done
);
  // Only the strobes need an idle level; address, data and mode are don't-care while the strobes are low
  initial begin
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    table_read_op <= 1'b0;
    table_write_op <= 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd
  task automatic unlock();
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_KEY, KEY_SECOND);
  endtask : unlock
  task automatic set_ptr(input logic [21:0] p);
    wr(OFS_PTR_UPPER, {2'b00, p[21:16]});
    wr(OFS_PTR_HIGH, p[15:8]);
    wr(OFS_PTR_LOW, p[7:0]);
  endtask : set_ptr
  task automatic top(input logic w, input tpf_mode_e m, output logic dn);
    table_write_op <= w;
    table_read_op <= !w;
    table_mode <= m;
    @(posedge clk_sys);
    {table_write_op, table_read_op} <= 2'b00;
    @(posedge clk_sys);
    dn = table_done;
  endtask : top
endmodule : tpf_core_model

// *** dv/tpf_sequencer_tb_top.sv ***
// Purpose: self-checking bench for tpf_sequencer
// Assumes: long cycles shortened to 9 clocks (timers loaded with 8)
// Notes: the core model drives every input but clk_sys and rst
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tpf_sequencer_tb_top import tpf_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic table_read_op;
  logic table_write_op;
  logic [1:0] table_mode;
  logic table_done;
  logic core_stall;
  logic [7:0] d;
  logic dn;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  tpf_core_model core (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .table_read_op(table_read_op), .table_write_op(table_write_op),
    .table_mode(table_mode), .table_done(table_done));
  tpf_sequencer #(.ERASE_CYCLES(8), .WRITE_CYCLES(8)) DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .table_read_op(table_read_op),
    .table_write_op(table_write_op), .table_mode(table_mode), .table_done(table_done), .core_stall(core_stall));
  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string n);
    core.rd(a, d);
    `CHK(n, e, d)
  endtask : rchk
  task automatic wait_idle();
    for (int i = 0; i < 40 && core_stall !== 1'b0; i++) @(posedge clk_sys);
    `CHK("stall end", 1'b0, core_stall)
  endtask : wait_idle
  task automatic t_erase();
    core.set_ptr(22'h000755);
    core.wr(OFS_CTRL, 8'h14);
    core.unlock();
    core.wr(OFS_CTRL, 8'h16);
    `CHK("stall", 1'b1, core_stall)
    core.top(1'b0, TPF_NOCHG, dn);
    `CHK("stalled op", 1'b0, dn)
    rchk(OFS_CTRL, 8'h1e, "busy ctrl");
    rchk(OFS_STATUS, 8'h01, "busy status");
    wait_idle();
    rchk(OFS_CTRL, 8'h04, "ctrl done");
    core.set_ptr(22'h000400);
    core.top(1'b0, TPF_NOCHG, dn);
    rchk(OFS_LATCH, 8'hff, "row first");
    core.set_ptr(22'h0007ff);
    core.top(1'b0, TPF_NOCHG, dn);
    rchk(OFS_LATCH, 8'hff, "row last");
  endtask : t_erase
  task automatic t_prog();
    core.set_ptr(22'h000440);
    for (int i = 0; i < 64; i++) begin
      core.wr(OFS_LATCH, 8'(i));
      core.top(1'b1, TPF_POSTINC, dn);
    end
    core.set_ptr(22'h000440);
    core.unlock();
    core.wr(OFS_CTRL, 8'h06);
    wait_idle();
    rchk(OFS_CTRL, 8'h04, "ctrl prog");
    core.top(1'b0, TPF_POSTINC, dn);
    rchk(OFS_LATCH, 8'h00, "byte 0");
    core.top(1'b0, TPF_PREINC, dn);
    rchk(OFS_LATCH, 8'h02, "preinc");
    core.top(1'b0, TPF_POSTDEC, dn);
    rchk(OFS_LATCH, 8'h02, "postdec");
    core.top(1'b0, TPF_NOCHG, dn);
    rchk(OFS_LATCH, 8'h01, "odd byte");
    rchk(OFS_PTR_LOW, 8'h41, "ptr low");
    `CHK("done", 1'b1, dn)
  endtask : t_prog
  task automatic t_bad();
    for (int k = 0; k < 4; k++) begin
      core.wr(OFS_CTRL, 8'h04);
      if (k == 1) core.wr(OFS_KEY, KEY_SECOND);
      if (k != 0) core.wr(OFS_KEY, KEY_FIRST);
      if (k == 2) core.wr(OFS_PTR_HIGH, 8'h04);
      if (k >= 2) core.wr(OFS_KEY, KEY_SECOND);
      core.wr(OFS_CTRL, k == 3 ? 8'h02 : 8'h06);
      `CHK("refused", 1'b0, core_stall)
      core.rd(OFS_CTRL, d);
      `CHK("err flag", 1'b1, d[CTRL_ERR])
    end
    rchk(OFS_STATUS, 8'h02, "err seen");
  endtask : t_bad
  task automatic t_cut();
    core.wr(OFS_CTRL, 8'h04);
    core.unlock();
    core.wr(OFS_CTRL, 8'h06);
    `CHK("cut stall", 1'b1, core_stall)
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("cut stall end", 1'b0, core_stall)
    rchk(OFS_CTRL, 8'h08, "cut err");
    rchk(OFS_STATUS, 8'h00, "status reset");
  endtask : t_cut
  task automatic t_top();
    core.set_ptr(22'h3fffff);
    core.top(1'b0, TPF_POSTINC, dn);
    rchk(OFS_PTR_UPPER, 8'h20, "top bit");
    rchk(OFS_PTR_LOW, 8'h00, "ptr wrap");
  endtask : t_top
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    core.rd(OFS_CTRL, d);
    `CHK("wen reset", 1'b0, d[CTRL_WEN])
    rchk(OFS_KEY, 8'h00, "key read");
    t_erase();
    t_prog();
    t_bad();
    t_cut();
    t_top();
    final_report();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
endmodule : tpf_sequencer_tb_top
bind tpf_sequencer tpf_seq_chk #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .table_read_op(table_read_op), .table_write_op(table_write_op), .table_mode(table_mode),
  .table_done(table_done), .core_stall(core_stall));
